// >>> clw_lowpower_wake.sv
// Purpose: Power-save response, bus wake-up and receive timestamp pulse for a CAN node.
// Assumes: clk keeps running for this logic in Sleep (it models the always-on part);
//          bus_receive_pin and all controls are synchronous to clk.
// Notes:   The protocol engine supplies frame_ok_eof and its own transmit level.
`timescale 1ns/1ps
`default_nettype none
module clw_lowpower_wake
   import clw_pkg::*;
#(
   parameter int unsigned BIT_CYC  = BIT_CYCLES,       // Cycles in one bit time.
   parameter int unsigned FILT_CYC = WAKE_FILT_CYCLES  // Glitch filter length.
) (
   input  wire logic clk,                          // System clock, 125 MHz.
   input  wire logic resetn,                       // Asynchronous reset, active low.
   input  wire logic power_save_exec,              // Power-save instruction executed.
   input  wire logic power_save_operand,           // 1 Sleep, 0 Idle.
   input  wire logic cpu_wake,                     // CPU leaves Idle or Sleep.
   input  wire logic stop_in_idle_bit,             // Power down in Idle.
   input  wire logic wake_irq_enable,              // Allow bus wake-up interrupt.
   input  wire logic wake_irq_flag_clr,            // Software clears the wake flag.
   input  wire logic wake_glitch_filter_enable,    // Enable receive low-pass filter.
   input  wire logic rx_timestamp_capture_enable,  // Enable timestamp pulses.
   input  wire logic module_enable_set,            // Software enables the module.
   input  wire logic module_enable_clr,            // Software disables the module.
   input  wire logic bus_receive_pin,              // CAN receive level.
   input  wire logic engine_tx,                    // Transmit level from engine.
   input  wire logic frame_ok_eof,                 // Accepted frame, EOF done cleanly.
   input  wire logic capture_two_pin,              // Capture channel two pin.
   output logic      bus_transmit_pin,             // CAN transmit level.
   output logic      wake_irq_flag,                // Sticky wake-up flag.
   output logic      wake_to_cpu,                  // Pulse: bus wake-up request.
   output logic      module_enabled,               // Module enable state.
   output logic      module_clk_en,                // Module clocks running.
   output logic      frame_store_en,               // Received frames may be stored.
   output logic      cpu_sleeping,                 // Power state is Sleep.
   output logic      rx_timestamp_pulse,           // One-bit-time pulse after EOF.
   output logic      capture_channel_two           // Input to capture channel two.
);

   localparam int unsigned BW = $clog2(BIT_CYC + 1);
   localparam logic [BW-1:0] BIT_LAST = BW'(BIT_CYC - 1);
   localparam int unsigned FW = $clog2(FILT_CYC + 1);

   // ------------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------------
   clw_pstate_t   ps_q, ps_d;
   logic          en_q, en_d;
   logic          flag_q, flag_d;
   logic          wreq_q, wreq_d;
   logic          tx_q, tx_d;
   logic          ts_q, ts_d;
   logic          cap_q, cap_d;
   logic [BW-1:0] bcnt_q, bcnt_d;
   logic          filt_dom;
   logic          bus_act;
   logic          powered_down;
   logic          wake_evt;
   logic [BW-1:0] tlen_q, tlen_d;
   logic [FW-1:0] drun_q, drun_d;

   // ------------------------------------------------------------------------
   // Receive activity detection
   // ------------------------------------------------------------------------
   // The filter is held clear outside Sleep so a long dominant run that began
   // while awake cannot fire the moment Sleep is entered.
   clw_glitch_filter #(
      .FILT_CYCLES (FILT_CYC)
   ) u_filt (
      .clk     (clk),
      .resetn  (resetn),
      .clear   (ps_q != PS_SLEEP),
      .rx_in   (bus_receive_pin),
      .dom_out (filt_dom)
   );

   // Activity is a dominant level, filtered when the filter is on.
   assign bus_act = wake_glitch_filter_enable ? filt_dom
                                              : (bus_receive_pin == BUS_DOMINANT);

   // Only Sleep with the interrupt enabled may produce a wake event.
   assign wake_evt = (ps_q == PS_SLEEP) && wake_irq_enable && bus_act;

   // Powered down in Sleep and Wake, or in Idle with stop-in-idle set.
   assign powered_down = (ps_q == PS_SLEEP) || (ps_q == PS_WAKE) ||
                         ((ps_q == PS_IDLE) && stop_in_idle_bit);

   // ------------------------------------------------------------------------
   // Power state machine
   // ------------------------------------------------------------------------
   always_comb begin
      ps_d = ps_q;
      case (ps_q)
         PS_RUN: begin
            if (power_save_exec) begin
               ps_d = (power_save_operand == PSAVE_OP_SLEEP) ? PS_SLEEP : PS_IDLE;
            end
         end
         PS_IDLE: begin
            if (cpu_wake) begin
               ps_d = PS_RUN;
            end
         end
         PS_SLEEP: begin
            if (wake_evt) begin
               ps_d = PS_WAKE;
            end else if (cpu_wake) begin
               ps_d = PS_RUN;
            end
         end
         PS_WAKE: begin
            ps_d = PS_RUN;   // Oscillator restart; the waking frame is already gone.
         end
         default: begin
            ps_d = PS_RUN;
         end
      endcase
   end

   // ------------------------------------------------------------------------
   // Module enable, wake flag and wake request
   // ------------------------------------------------------------------------
   // A bus wake forces the module off; software must enable it again. The
   // wake flag set beats a clear arriving in the same cycle.
   always_comb begin
      en_d = en_q;
      if (module_enable_set) begin
         en_d = 1'b1;
      end
      if (module_enable_clr || wake_evt) begin
         en_d = 1'b0;
      end
      flag_d = flag_q;
      if (wake_irq_flag_clr) begin
         flag_d = 1'b0;
      end
      if (wake_evt) begin
         flag_d = 1'b1;
      end
      wreq_d = wake_evt;
   end

   // ------------------------------------------------------------------------
   // Transmit pin, timestamp pulse and capture routing
   // ------------------------------------------------------------------------
   // Timestamps need a running, enabled module, so the frame that woke the
   // node is never timestamped or stored.
   always_comb begin
      tx_d   = (powered_down || !en_q) ? BUS_RECESSIVE : engine_tx;
      ts_d   = ts_q;
      bcnt_d = bcnt_q;
      if (ts_q) begin
         if (bcnt_q == BIT_LAST) begin
            ts_d   = 1'b0;
            bcnt_d = '0;
         end else begin
            bcnt_d = bcnt_q + BW'(1);
         end
      end else if (frame_ok_eof && rx_timestamp_capture_enable &&
                   en_q && !powered_down) begin
         ts_d   = 1'b1;
         bcnt_d = '0;
      end
      if (!rx_timestamp_capture_enable) begin
         ts_d   = 1'b0;
         bcnt_d = '0;
      end
      cap_d = rx_timestamp_capture_enable ? ts_d : capture_two_pin;
   end

   // Registers only.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ps_q   <= PS_RUN;
         en_q   <= 1'b0;
         flag_q <= 1'b0;
         wreq_q <= 1'b0;
         tx_q   <= BUS_RECESSIVE;
         ts_q   <= 1'b0;
         cap_q  <= 1'b0;
         bcnt_q <= '0;
      end else begin
         ps_q   <= ps_d;
         en_q   <= en_d;
         flag_q <= flag_d;
         wreq_q <= wreq_d;
         tx_q   <= tx_d;
         ts_q   <= ts_d;
         cap_q  <= cap_d;
         bcnt_q <= bcnt_d;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------------
   assign bus_transmit_pin    = tx_q;
   assign wake_irq_flag       = flag_q;
   assign wake_to_cpu         = wreq_q;
   assign module_enabled      = en_q;
   assign module_clk_en       = !powered_down;
   assign frame_store_en      = en_q && !powered_down;
   assign cpu_sleeping        = (ps_q == PS_SLEEP);
   assign rx_timestamp_pulse  = ts_q;
   assign capture_channel_two = cap_q;

   // ------------------------------------------------------------------------
   // Check helpers
   // ------------------------------------------------------------------------
   // Independent counts for the checks below: how long the pulse has stood,
   // and how many dominant samples in a row Sleep has seen. They do not reuse
   // the design's own counters, so a broken counter cannot vouch for itself.
   always_comb begin
      tlen_d = '0;
      drun_d = '0;
      if (ts_q) begin
         tlen_d = (tlen_q == BW'(BIT_CYC)) ? tlen_q : tlen_q + BW'(1);
      end
      if ((ps_q == PS_SLEEP) && (bus_receive_pin == BUS_DOMINANT)) begin
         drun_d = (drun_q == FW'(FILT_CYC)) ? drun_q : drun_q + FW'(1);
      end
   end

   // Registers only.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tlen_q <= '0;
         drun_q <= '0;
      end else begin
         tlen_q <= tlen_d;
         drun_q <= drun_d;
      end
   end

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   sequence s_ts_start;
      ts_q && !$past(ts_q);
   endsequence

   sequence s_bus_wake;
      (ps_q == PS_SLEEP) ##1 (ps_q == PS_WAKE);
   endsequence

   a_tx_recessive_sleep: assert property (@(posedge clk) disable iff (!resetn)
      $past(powered_down) |-> bus_transmit_pin == BUS_RECESSIVE)
      else $error("Transmit pin not recessive while powered down.");

   a_sleep_entry: assert property (@(posedge clk) disable iff (!resetn)
      (ps_q == PS_RUN && power_save_exec && power_save_operand) |=> cpu_sleeping && !module_clk_en)
      else $error("Sleep entry did not stop module clocks.");

   a_idle_stop: assert property (@(posedge clk) disable iff (!resetn)
      (ps_q == PS_IDLE) |-> module_clk_en == !stop_in_idle_bit)
      else $error("Idle clock state does not follow stop-in-idle.");

   a_wake_flag_set: assert property (@(posedge clk) disable iff (!resetn)
      wake_evt |=> wake_irq_flag && wake_to_cpu ##1 !wake_to_cpu)
      else $error("Wake event did not set flag and single request.");

   a_wake_only_sleep: assert property (@(posedge clk) disable iff (!resetn)
      $rose(wake_irq_flag) |-> $past(ps_q) == PS_SLEEP && $past(wake_irq_enable))
      else $error("Wake flag set outside Sleep or while disabled.");

   a_wake_flag_hold: assert property (@(posedge clk) disable iff (!resetn)
      (wake_irq_flag && !wake_irq_flag_clr) |=> wake_irq_flag)
      else $error("Wake flag dropped without a clear.");

   a_wake_flag_clear: assert property (@(posedge clk) disable iff (!resetn)
      (wake_irq_flag_clr && !wake_evt) |=> !wake_irq_flag)
      else $error("Wake flag not cleared by software.");

   a_wake_disables: assert property (@(posedge clk) disable iff (!resetn)
      s_bus_wake |-> !module_enabled ##1 (ps_q == PS_RUN &&
         frame_store_en == $past(module_enable_set && !module_enable_clr)))
      else $error("Module not left disabled after bus wake.");

   a_wake_no_filter_glitch: assert property (@(posedge clk) disable iff (!resetn)
      (wake_glitch_filter_enable && wake_evt) |-> drun_q == FW'(FILT_CYC))
      else $error("Filtered wake fired before the filter time elapsed.");

   a_ts_cause: assert property (@(posedge clk) disable iff (!resetn)
      s_ts_start |-> $past(frame_ok_eof) && $past(rx_timestamp_capture_enable)
                     && $past(en_q))
      else $error("Timestamp pulse without an accepted frame.");

   a_ts_width: assert property (@(posedge clk) disable iff (!resetn)
      ($fell(rx_timestamp_pulse) && $past(rx_timestamp_capture_enable)) |-> tlen_q == BW'(BIT_CYC))
      else $error("Timestamp pulse shorter than one bit time.");

   a_ts_max_width: assert property (@(posedge clk) disable iff (!resetn)
      rx_timestamp_pulse |-> tlen_q < BW'(BIT_CYC))
      else $error("Timestamp pulse stood past one bit time.");

   a_ts_disable_drop: assert property (@(posedge clk) disable iff (!resetn)
      !rx_timestamp_capture_enable |=> !rx_timestamp_pulse)
      else $error("Timestamp pulse present while capture is disabled.");

   a_ts_end: assert property (@(posedge clk) disable iff (!resetn)
      (ts_q && bcnt_q == BIT_LAST) |=> !ts_q)
      else $error("Timestamp pulse longer than one bit time.");

   a_cap_route: assert property (@(posedge clk) disable iff (!resetn)
      $past(rx_timestamp_capture_enable) |-> capture_channel_two == ts_q)
      else $error("Capture channel two not fed from timestamp.");

endmodule : clw_lowpower_wake
`default_nettype wire

// >>> clw_pkg.sv
// Purpose: Shared constants for the CAN low-power, wake-up and timestamp block.
// Assumes: 125 MHz system clock, all control bits arrive as plain ports.
// Notes:   Bit positions are kept for software-visible documentation only.
// Function
// - Power-save operand 1 stops all clocks; operand 0 may stop module clocks.
// - While sleeping or powered down, the transmit pin is held recessive.
// - In Idle, module powers down if stop-in-idle is 1, runs if 0.
// - In Sleep, bus activity raises the wake flag when wake enable is set.
// - The frame that caused the wake-up is neither received nor stored.
// - After a bus wake-up the module stays disabled until software re-enables it.
// - Wake-up detection works only in Sleep, never in Idle or run.
// - Optional low-pass filter on receive input suppresses glitch wake-ups.
// - Each valid accepted frame gives a one-bit-time pulse right after EOF; the code ignores an EOF that comes while a pulse still stands.
// - Timestamp pulses are produced only while capture enable is set.
// - With capture enabled, capture channel two takes the CAN timestamp, not its pin.
package clw_pkg;

   // -------------------------------------------------------------------------
   // Field positions and levels
   // -------------------------------------------------------------------------
   localparam int unsigned STOP_IN_IDLE_POS = 13;   // Bit of control_reg_one.
   localparam int unsigned RX_CAP_EN_POS    = 3;    // Bit of control_reg_one.
   localparam logic        BUS_RECESSIVE    = 1'b1;
   localparam logic        BUS_DOMINANT     = 1'b0;
   localparam logic        PSAVE_OP_SLEEP   = 1'b1;
   localparam logic        PSAVE_OP_IDLE    = 1'b0;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS    = 8000;
   localparam int unsigned BIT_TIME_NS      = 1000;  // Fastest bit rate, 1 Mbps.
   localparam int unsigned BIT_CYCLES       = (BIT_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned WAKE_FILT_NS     = 400;   // Least dominant time to wake.
   localparam int unsigned WAKE_FILT_CYCLES =
      (WAKE_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // -------------------------------------------------------------------------
   // Power state, Gray coded in the order run -> idle -> sleep -> wake -> run
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      PS_RUN   = 2'b00,
      PS_IDLE  = 2'b01,
      PS_SLEEP = 2'b11,
      PS_WAKE  = 2'b10
   } clw_pstate_t;

endpackage : clw_pkg

// >>> clw_glitch_filter.sv
// Purpose: Low-pass filter for the receive line used by wake-up detection.
// Assumes: Input is synchronous to clk.
// Notes:   Output goes dominant only after FILT_CYCLES consecutive dominant samples.
`timescale 1ns/1ps
`default_nettype none
module clw_glitch_filter
   import clw_pkg::*;
#(
   parameter int unsigned FILT_CYCLES = WAKE_FILT_CYCLES
) (
   input  wire logic clk,      // System clock.
   input  wire logic resetn,   // Asynchronous reset, active low.
   input  wire logic clear,    // Restart the filter.
   input  wire logic rx_in,    // Raw receive level.
   output logic      dom_out   // Filtered dominant indication.
);

   localparam int unsigned CW = $clog2(FILT_CYCLES + 1);
   localparam logic [CW-1:0] CNT_MAX = CW'(FILT_CYCLES);

   logic [CW-1:0] cnt_q, cnt_d;
   logic          dom_q, dom_d;

   // ------------------------------------------------------------------------
   // Count consecutive dominant samples; any recessive sample restarts it.
   // ------------------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      dom_d = dom_q;
      if (clear || rx_in == BUS_RECESSIVE) begin
         cnt_d = '0;
         dom_d = 1'b0;
      end else if (cnt_q != CNT_MAX) begin
         cnt_d = cnt_q + CW'(1);
         dom_d = (cnt_q + CW'(1)) == CNT_MAX;
      end
   end

   // Registers only.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
         dom_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         dom_q <= dom_d;
      end
   end

   assign dom_out = dom_q;

   // A short glitch never reaches the output.
   a_filt_min_width: assert property (@(posedge clk) disable iff (!resetn)
      $rose(dom_q) |-> $past(rx_in) == BUS_DOMINANT)
      else $error("Filter output rose after a recessive sample.");

endmodule : clw_glitch_filter
`default_nettype wire

// >>> clw_bus_partner.sv
// Purpose: Far-side model of the CAN bus through a transceiver, plus the timer capture unit.
// Assumes: Bus is a wired-AND with a pull-up, so recessive whenever nobody pulls it low.
// Notes:   The bench asks for dominant bus activity through dom_req.
`timescale 1ns/1ps
`default_nettype none
module clw_bus_partner (
   input  wire logic       clk,            // System clock.
   input  wire logic       resetn,         // Asynchronous reset, active low.
   input  wire logic       tx_level,       // Our node's transmit level.
   input  wire logic       dom_req,        // Other nodes drive dominant.
   input  wire logic       capture_in,     // Capture channel two input.
   output wire logic       rx_level,       // Level seen back at the receiver.
   output var  logic [7:0] capture_count   // Rising edges seen by the capture unit.
);
   logic cap_prev_q;

   // -------------------------------------------------------------------------
   // Bus and capture unit
   // -------------------------------------------------------------------------
   // Wired-AND: any dominant driver wins, the pull-up gives recessive otherwise.
   assign rx_level = tx_level & ~dom_req;

   // The capture unit counts rising edges, as a timer would on each timestamp.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cap_prev_q    <= 1'b0;
         capture_count <= 8'h00;
      end else begin
         cap_prev_q <= capture_in;
         if (capture_in && !cap_prev_q) begin
            capture_count <= capture_count + 8'h01;
         end
      end
   end
endmodule : clw_bus_partner
`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for power-save, bus wake-up and timestamp behaviour.
// Assumes: Short counts BIT_CYC=4 and FILT_CYC=3 keep the run brief.
// Notes:   Inputs change 1 ns after the rising edge; every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
   $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
   import clw_pkg::*;
   localparam int unsigned BIT_N  = 4;
   localparam int unsigned FILT_N = 3;
   logic clk = 1'b0, resetn = 1'b0, psx = 1'b0, pso = 1'b0, cpu_wake = 1'b0;
   logic stop_idle = 1'b0, wk_en = 1'b0, wk_clr = 1'b0, filt_en = 1'b0, cap_en = 1'b0;
   logic en_set = 1'b0, en_clr = 1'b0, engine_tx = 1'b1, eof = 1'b0, cap_pin = 1'b0;
   logic dom_req = 1'b0;
   logic rx, tx, flag, wake_cpu, enabled, clk_en, store_en, sleeping, ts_pulse, cap_two;
   logic [7:0] cap_cnt;
   int bad_count = 0, n_compared = 0;

   always #4 clk = ~clk;

   clw_lowpower_wake #(.BIT_CYC(BIT_N), .FILT_CYC(FILT_N)) u_dut (
      .clk(clk), .resetn(resetn), .power_save_exec(psx), .power_save_operand(pso),
      .cpu_wake(cpu_wake), .stop_in_idle_bit(stop_idle), .wake_irq_enable(wk_en),
      .wake_irq_flag_clr(wk_clr), .wake_glitch_filter_enable(filt_en),
      .rx_timestamp_capture_enable(cap_en), .module_enable_set(en_set),
      .module_enable_clr(en_clr), .bus_receive_pin(rx), .engine_tx(engine_tx),
      .frame_ok_eof(eof), .capture_two_pin(cap_pin), .bus_transmit_pin(tx),
      .wake_irq_flag(flag), .wake_to_cpu(wake_cpu), .module_enabled(enabled),
      .module_clk_en(clk_en), .frame_store_en(store_en), .cpu_sleeping(sleeping),
      .rx_timestamp_pulse(ts_pulse), .capture_channel_two(cap_two));

   clw_bus_partner u_bus (
      .clk(clk), .resetn(resetn), .tx_level(tx), .dom_req(dom_req), .capture_in(cap_two),
      .rx_level(rx), .capture_count(cap_cnt));

   // -------------------------------------------------------------------------
   // Access tasks
   // -------------------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // Each request is held across exactly one sampling edge.
   task automatic psave(input logic op);
      psx = 1'b1;
      pso = op;
      tick(1);
      psx = 1'b0;
   endtask : psave

   task automatic wake_cpu_now();
      cpu_wake = 1'b1;
      tick(1);
      cpu_wake = 1'b0;
   endtask : wake_cpu_now

   task automatic enable_mod(input logic on);
      en_set = on;
      en_clr = ~on;
      tick(1);
      en_set = 1'b0;
      en_clr = 1'b0;
   endtask : enable_mod

   task automatic clear_flag();
      wk_clr = 1'b1;
      tick(1);
      wk_clr = 1'b0;
   endtask : clear_flag

   // Waits a bounded time for the wake pulse; a lost wake-up ends the run.
   task automatic wait_wake();
      int i;
      for (i = 0; i < 20 && wake_cpu !== 1'b1; i++) tick(1);
      if (wake_cpu !== 1'b1) begin
         bad_count++;
         $display("[ERR] wake_to_cpu expected 1 seen %0h", wake_cpu);
         final_report();
      end
   endtask : wait_wake

   task automatic final_report();
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   initial begin
      int i;
      tick(16);
      resetn = 1'b1;
      `CHK("tx_rst", BUS_RECESSIVE, tx)
      `CHK("clk_en_rst", 1'b1, clk_en)
      `CHK("flag_rst", 1'b0, flag)
      // A running, enabled module passes the engine level through.
      enable_mod(1'b1);
      engine_tx = BUS_DOMINANT;
      tick(2);
      `CHK("tx_run", BUS_DOMINANT, tx)
      // Idle with stop-in-idle clear keeps clocks; a dominant bus must not wake.
      wk_en = 1'b1;
      psave(PSAVE_OP_IDLE);
      `CHK("clk_en_idle0", 1'b1, clk_en)
      `CHK("store_idle0", 1'b1, store_en)
      tick(3);
      `CHK("flag_idle0", 1'b0, flag)
      wake_cpu_now();
      // Idle with stop-in-idle set powers down and forces recessive.
      stop_idle = 1'b1;
      psave(PSAVE_OP_IDLE);
      `CHK("clk_en_idle1", 1'b0, clk_en)
      `CHK("sleep_idle1", 1'b0, sleeping)
      tick(1);
      `CHK("tx_idle1", BUS_RECESSIVE, tx)
      `CHK("flag_idle1", 1'b0, flag)
      wake_cpu_now();
      `CHK("clk_en_back", 1'b1, clk_en)
      stop_idle = 1'b0;
      // Sleep with wake disabled: recessive output, activity ignored.
      wk_en = 1'b0;
      psave(PSAVE_OP_SLEEP);
      `CHK("sleeping", 1'b1, sleeping)
      `CHK("clk_en_sleep", 1'b0, clk_en)
      dom_req = 1'b1;
      tick(4);
      `CHK("tx_sleep", BUS_RECESSIVE, tx)
      `CHK("flag_wk_off", 1'b0, flag)
      dom_req = 1'b0;
      wake_cpu_now();
      `CHK("sleep_exit", 1'b0, sleeping)
      // Filtered sleep: a short glitch is rejected, a long dominant wakes.
      engine_tx = BUS_RECESSIVE;
      wk_en = 1'b1;
      filt_en = 1'b1;
      psave(PSAVE_OP_SLEEP);
      tick(2);
      dom_req = 1'b1;
      tick(FILT_N - 1);
      dom_req = 1'b0;
      tick(4);
      `CHK("flag_glitch", 1'b0, flag)
      `CHK("still_asleep", 1'b1, sleeping)
      dom_req = 1'b1;
      wait_wake();
      `CHK("flag_wake", 1'b1, flag)
      `CHK("enabled_wake", 1'b0, enabled)
      tick(1);
      dom_req = 1'b0;
      `CHK("wake_pulse_end", 1'b0, wake_cpu)
      `CHK("clk_en_wake", 1'b1, clk_en)
      `CHK("store_wake", 1'b0, store_en)
      tick(5);
      `CHK("flag_sticky", 1'b1, flag)
      `CHK("still_disabled", 1'b0, enabled)
      clear_flag();
      `CHK("flag_clr", 1'b0, flag)
      // Unfiltered sleep after a proper disable: one dominant sample wakes.
      filt_en = 1'b0;
      enable_mod(1'b0);
      psave(PSAVE_OP_SLEEP);
      tick(2);
      dom_req = 1'b1;
      tick(1);
      dom_req = 1'b0;
      wait_wake();
      `CHK("flag_raw", 1'b1, flag)
      clear_flag();
      // Timestamp: one pulse of BIT_N cycles; a second end-of-frame inside it is ignored.
      enable_mod(1'b1);
      cap_en = 1'b1;
      cap_pin = 1'b1;
      tick(2);
      `CHK("cap_pin_blocked", 1'b0, cap_two)
      eof = 1'b1;
      tick(1);
      for (i = 0; i < BIT_N; i++) begin
         `CHK("ts_pulse_on", 1'b1, ts_pulse)
         `CHK("cap_two_on", 1'b1, cap_two)
         eof = (i == 0);
         tick(1);
      end
      `CHK("ts_pulse_off", 1'b0, ts_pulse)
      tick(1);
      `CHK("ts_no_retrig", 1'b0, ts_pulse)
      `CHK("captures", 8'h01, cap_cnt)
      // Capture dropped mid-pulse: the pulse ends at once, though end-of-frame is
      // still high at that edge; channel two then follows its own pin.
      eof = 1'b1;
      tick(1);
      `CHK("ts_restart", 1'b1, ts_pulse)
      cap_en = 1'b0;
      tick(1);
      `CHK("ts_drop", 1'b0, ts_pulse)
      eof = 1'b0;
      tick(1);
      `CHK("ts_disabled", 1'b0, ts_pulse)
      for (i = 0; i < 2; i++) begin
         cap_pin = i[0];
         tick(1);
         `CHK("cap_two_pin", cap_pin, cap_two)
      end
      final_report();
   end
endmodule : testbench
`default_nettype wire
